// >>> inc/loopback_map.svh
`ifndef LOOPBACK_MAP_SVH
`define LOOPBACK_MAP_SVH
// Contract
// - Remote loop sends recovered data to transmit; with local loop also set, code sends transmit data instead
// - Remote loop ignores transmit data inputs; with local loop also set, code drives transmit from them
// - Loop-up code held 5 s enters auto loop
// - Loop-down code held 5 s leaves auto loop
// - Auto enable falling resets auto loop circuitry
// - Remote loop is manual OR automatic
// - Analog loop feeds line outputs to receiver
// - Analog loop ignores line inputs, still transmits
// - Jitter bypass skips attenuator, backplane keeps it; code bypasses rx_out only, and not in local loop
// - Three low control bits select error counter
// - Events and alarms set their status bits
// - Latched bits clear on read, real-time follow
// - Carrier loss, all-ones stay set while present
// - Status write of one refreshes, zero holds
// - Only main status bits can interrupt
// - Mask register gates each main status bit
// - Three alarms interrupt on every state change
// - Alarm interrupt released by reading its bit
// - Other bits interrupt on set, read releases
// - Local loop sends transmit data to receive
// - Mask bit zero masks, one enables
`define ADDR_CTRL 8'h05
`define ADDR_SR 8'h06
`define ADDR_IMR 8'h07
`define ADDR_RX_INFO_REG_1 8'h08
`define ADDR_RX_INFO_REG_2 8'h09
`define CTRL_LOCAL 7
`define CTRL_REMOTE 6
`define CTRL_AUTO 5
`define CTRL_ANALOG 4
`define CTRL_JBYP 3
`define CTRL_SEL_HI 2
`define CTRL_SEL_LO 0
`define CTRL_RST 8'h00
`define IMR_RST 8'h00
`define STAT_RST 8'h00
`define SR_TX_CLOCK_LOSS 5
`define SR_UNFRAMED_ONES_ALARM 4
`define SR_RCL 3
`define SR_LATCHED 8'hD8
`define SR_PERSIST 8'h18
`define SR_COS 8'h38
`define RX_INFO_REG_1_ZD 7
`define RX_INFO_REG_1_ZD16 6
`define RX_INFO_REG_1_HBD 5
`define RX_INFO_REG_1_RCLC 4
`define RX_INFO_REG_1_RUA1C 3
`define RX_INFO_REG_1_JALT 2
`define RX_INFO_REG_1_LATCHED 8'hFC
`define RX_INFO_REG_2_AUTO 1
`define RX_INFO_REG_2_LATCHED 8'hFD
`define LOOP_HOLD_MS 5000
`define CLK_HZ 100000000
`define LOOP_HOLD_CYC (`LOOP_HOLD_MS * (`CLK_HZ / 1000))
`endif

// >>> inc/loopback_pkg.sv
package loopback_pkg;
	typedef struct packed {
		logic pos;
		logic neg;
	} line_pair_t;
	typedef struct packed {
		logic loop_up_det;
		logic loop_down_det;
		logic tx_clock_loss;
		logic unframed_ones_alarm;
		logic carrier_loss_alarm;
		logic tx_current_limit;
		logic tx_open_circuit;
		logic prbs_det;
		logic zero_det;
		logic zero16_det;
		logic code_word_det;
		logic jitter_limit;
		logic [7:0] rx_info_reg_2_evt;
	} stat_in_t;
	typedef struct packed {
		line_pair_t rec;
		line_pair_t tx;
		line_pair_t line_in;
		line_pair_t ja_out;
		logic ja_en;
	} path_in_t;
	typedef struct packed {
		line_pair_t tx_drv;
		line_pair_t rx_out;
		line_pair_t ja_in;
		line_pair_t rx_front;
	} path_out_t;
	typedef enum logic {
		AUTO_IDLE,
		AUTO_LOOPED
	} auto_state_t;
	typedef struct packed {
		logic [31:0] cnt;
		logic done;
	} hold_state_t;
endpackage

// >>> src/code_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module code_hold_timer #(
	parameter int unsigned CYCLES = 32'h0000_03E8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Detection
	input wire logic det,
	input wire logic clr,
	output logic done
);
	loopback_pkg::hold_state_t s_r;
	loopback_pkg::hold_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (clr || !det) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt == 32'(CYCLES - 1)) begin
			// Code seen without break for the whole hold time
			s_nxt.done = 1'b1;
			s_nxt.cnt = '0;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;
endmodule // code_hold_timer
`default_nettype wire

// >>> src/loopback_status_interrupt_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "loopback_map.svh"
module loopback_status_interrupt_control #(
	parameter int unsigned HOLD_CYCLES = `LOOP_HOLD_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Parallel host port
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// Alarm and event sources
	input wire loopback_pkg::stat_in_t stat_in,
	// Line data paths
	input wire loopback_pkg::path_in_t path_in,
	output loopback_pkg::path_out_t path_out,
	// Control outputs
	output logic [2:0] err_count_sel,
	output logic remote_loop_active,
	output logic bp_clk_via_ja,
	// Interrupt
	output logic irq_n
);
	typedef struct packed {
		logic [1:0] cs_n_s;
		logic [1:0] rd_n_s;
		logic [1:0] wr_n_s;
		logic [1:0][7:0] addr_s;
		logic [1:0][7:0] din_s;
		loopback_pkg::stat_in_t [1:0] stat_s;
		loopback_pkg::path_in_t [1:0] path_s;
		logic rd_act;
		logic wr_act;
		logic [7:0] rd_addr;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic [7:0] ctrl;
		logic [7:0] irq_mask_reg;
		logic [2:0][7:0] lat;
		logic [2:0][7:0] view;
		logic [2:0][7:0] wmask;
		logic [7:0] prev_raw;
		logic [7:0] prev_r1;
		logic [7:0] prev_r2;
		logic [7:0] pend;
		loopback_pkg::auto_state_t auto_st;
		logic remote;
		logic bp_ja;
		logic irq_n;
		logic [7:0] dout;
		logic doe;
		loopback_pkg::path_out_t pout;
	} core_state_t;

	localparam logic [2:0][7:0] LATCH_M = {
		`RX_INFO_REG_2_LATCHED,
		`RX_INFO_REG_1_LATCHED,
		`SR_LATCHED
	};
	localparam logic [2:0][7:0] STAT_ADDR = {
		`ADDR_RX_INFO_REG_2,
		`ADDR_RX_INFO_REG_1,
		`ADDR_SR
	};

	core_state_t s_r;
	core_state_t s_nxt;
	loopback_pkg::stat_in_t st;
	loopback_pkg::path_in_t pin;
	logic rd_now;
	logic wr_now;
	logic rd_start;
	logic rd_end;
	logic wr_end;
	logic [7:0] raw_sr;
	logic [7:0] raw_r1;
	logic [7:0] raw_r2;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] cos;
	logic [7:0] evt;
	logic [7:0] pclr;
	logic [2:0][7:0] setv;
	logic [2:0][7:0] rt;
	logic [2:0][7:0] live;
	logic [2:0][7:0] clr;
	logic [2:0] rhit;
	logic [2:0] whit;
	logic auto_en;
	logic auto_reset;
	logic up_det;
	logic down_det;
	logic up_done;
	logic down_done;
	logic local_lp;
	logic remote_lp;
	loopback_pkg::line_pair_t after_ja;

	code_hold_timer #(
		.CYCLES(HOLD_CYCLES)
	) up_timer (
		.ref_clk(ref_clk),
		.srst(srst),
		.det(up_det),
		.clr(auto_reset),
		.done(up_done)
	);

	code_hold_timer #(
		.CYCLES(HOLD_CYCLES)
	) down_timer (
		.ref_clk(ref_clk),
		.srst(srst),
		.det(down_det),
		.clr(auto_reset),
		.done(down_done)
	);

	always_comb begin
		s_nxt = s_r;
		// Two-flop synchronisers on every pin but ref_clk and srst
		s_nxt.cs_n_s = {s_r.cs_n_s[0], cs_n};
		s_nxt.rd_n_s = {s_r.rd_n_s[0], rd_n};
		s_nxt.wr_n_s = {s_r.wr_n_s[0], wr_n};
		s_nxt.addr_s = {s_r.addr_s[0], addr};
		s_nxt.din_s = {s_r.din_s[0], data_in};
		s_nxt.stat_s = {s_r.stat_s[0], stat_in};
		s_nxt.path_s = {s_r.path_s[0], path_in};
		st = s_r.stat_s[1];
		pin = s_r.path_s[1];

		// Strobe edges
		rd_now = !s_r.cs_n_s[1] && !s_r.rd_n_s[1];
		wr_now = !s_r.cs_n_s[1] && !s_r.wr_n_s[1];
		s_nxt.rd_act = rd_now;
		s_nxt.wr_act = wr_now;
		rd_start = rd_now && !s_r.rd_act;
		rd_end = !rd_now && s_r.rd_act;
		wr_end = !wr_now && s_r.wr_act;
		if (rd_start) begin
			s_nxt.rd_addr = s_r.addr_s[1];
		end
		if (wr_now) begin
			s_nxt.wr_addr = s_r.addr_s[1];
			s_nxt.wr_data = s_r.din_s[1];
		end

		// Raw conditions and their edges
		raw_sr = {
			st.loop_up_det,
			st.loop_down_det,
			st.tx_clock_loss,
			st.unframed_ones_alarm,
			st.carrier_loss_alarm,
			st.tx_current_limit,
			st.tx_open_circuit,
			st.prbs_det
		};
		rise = raw_sr & ~s_r.prev_raw;
		fall = ~raw_sr & s_r.prev_raw;
		s_nxt.prev_raw = raw_sr;
		raw_r1 = `STAT_RST;
		raw_r1[`RX_INFO_REG_1_ZD] = st.zero_det;
		raw_r1[`RX_INFO_REG_1_ZD16] = st.zero16_det;
		raw_r1[`RX_INFO_REG_1_HBD] = st.code_word_det;
		raw_r1[`RX_INFO_REG_1_JALT] = st.jitter_limit;
		s_nxt.prev_r1 = raw_r1;
		raw_r2 = st.rx_info_reg_2_evt & `RX_INFO_REG_2_LATCHED;
		s_nxt.prev_r2 = raw_r2;

		// Set terms per register
		setv[0] = (rise & `SR_LATCHED) | (raw_sr & `SR_PERSIST);
		setv[1] = raw_r1 & ~s_r.prev_r1;
		setv[1][`RX_INFO_REG_1_RCLC] = fall[`SR_RCL];
		setv[1][`RX_INFO_REG_1_RUA1C] = fall[`SR_UNFRAMED_ONES_ALARM];
		setv[2] = raw_r2 & ~s_r.prev_r2;
		rt[0] = raw_sr & ~`SR_LATCHED;
		rt[1] = `STAT_RST;
		rt[2] = `STAT_RST;
		rt[2][`RX_INFO_REG_2_AUTO] = (s_r.auto_st == loopback_pkg::AUTO_LOOPED);

		// Status registers
		for (int i = 0; i < 3; i++) begin
			rhit[i] = (s_r.rd_addr == STAT_ADDR[i]);
			whit[i] = (s_r.wr_addr == STAT_ADDR[i]);
			live[i] = (s_r.lat[i] & LATCH_M[i]) | rt[i];
			clr[i] = `STAT_RST;
			if (rd_end && rhit[i]) begin
				clr[i] = s_r.wmask[i] & s_r.view[i] & LATCH_M[i];
			end
			s_nxt.lat[i] = (s_r.lat[i] & ~clr[i]) | setv[i];
			if (wr_end && whit[i]) begin
				s_nxt.view[i] = (s_r.view[i] & ~s_r.wr_data) |
					(live[i] & s_r.wr_data);
				s_nxt.wmask[i] = s_r.wr_data;
			end
		end

		// Interrupt sources, main status only
		cos = (rise | fall) & `SR_COS;
		evt = rise & ~`SR_COS;
		pclr = `STAT_RST;
		if (rd_end && rhit[0]) begin
			pclr = s_r.wmask[0];
		end
		s_nxt.pend = (s_r.pend & ~pclr) | cos | evt;
		s_nxt.irq_n = ~|(s_nxt.pend & s_r.irq_mask_reg);

		// Control and mask writes
		auto_reset = 1'b0;
		if (wr_end && s_r.wr_addr == `ADDR_CTRL) begin
			s_nxt.ctrl = s_r.wr_data;
			auto_reset = s_r.ctrl[`CTRL_AUTO] &&
				!s_r.wr_data[`CTRL_AUTO];
		end
		if (wr_end && s_r.wr_addr == `ADDR_IMR) begin
			s_nxt.irq_mask_reg = s_r.wr_data;
		end

		// Automatic remote loopback
		auto_en = s_r.ctrl[`CTRL_AUTO];
		up_det = auto_en && st.loop_up_det &&
			s_r.auto_st == loopback_pkg::AUTO_IDLE;
		down_det = auto_en && st.loop_down_det &&
			s_r.auto_st == loopback_pkg::AUTO_LOOPED;
		unique case (s_r.auto_st)
			loopback_pkg::AUTO_IDLE: begin
				if (up_done) begin
					s_nxt.auto_st = loopback_pkg::AUTO_LOOPED;
				end
			end
			loopback_pkg::AUTO_LOOPED: begin
				if (down_done) begin
					s_nxt.auto_st = loopback_pkg::AUTO_IDLE;
				end
			end
		endcase
		if (auto_reset || !auto_en) begin
			s_nxt.auto_st = loopback_pkg::AUTO_IDLE;
		end

		// Data path routing
		local_lp = s_r.ctrl[`CTRL_LOCAL];
		remote_lp = s_r.ctrl[`CTRL_REMOTE] ||
			s_r.auto_st == loopback_pkg::AUTO_LOOPED;
		s_nxt.remote = remote_lp;
		after_ja = pin.ja_out;
		if (!pin.ja_en) begin
			after_ja = local_lp ? pin.tx : pin.rec;
		end
		s_nxt.pout.ja_in = local_lp ? pin.tx : pin.rec;
		if (remote_lp) begin
			s_nxt.pout.tx_drv = after_ja;
		end else begin
			s_nxt.pout.tx_drv = pin.tx;
		end
		if (local_lp) begin
			s_nxt.pout.rx_out = after_ja;
		end else if (s_r.ctrl[`CTRL_JBYP]) begin
			s_nxt.pout.rx_out = pin.rec;
		end else begin
			s_nxt.pout.rx_out = after_ja;
		end
		s_nxt.bp_ja = pin.ja_en;
		if (s_r.ctrl[`CTRL_ANALOG]) begin
			s_nxt.pout.rx_front = s_r.pout.tx_drv;
		end else begin
			s_nxt.pout.rx_front = pin.line_in;
		end

		// Read data
		if (rd_start) begin
			s_nxt.doe = 1'b1;
			s_nxt.dout = `STAT_RST;
			if (s_r.addr_s[1] == `ADDR_CTRL) begin
				s_nxt.dout = s_r.ctrl;
			end
			if (s_r.addr_s[1] == `ADDR_IMR) begin
				s_nxt.dout = s_r.irq_mask_reg;
			end
			for (int i = 0; i < 3; i++) begin
				if (s_r.addr_s[1] == STAT_ADDR[i]) begin
					s_nxt.dout = s_r.view[i];
				end
			end
		end
		if (rd_end) begin
			s_nxt.doe = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
			s_r.cs_n_s <= '1;
			s_r.rd_n_s <= '1;
			s_r.wr_n_s <= '1;
			s_r.ctrl <= `CTRL_RST;
			s_r.irq_mask_reg <= `IMR_RST;
			s_r.auto_st <= loopback_pkg::AUTO_IDLE;
			s_r.irq_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign data_out = s_r.dout;
	assign data_oe = s_r.doe;
	assign path_out = s_r.pout;
	assign err_count_sel = s_r.ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO];
	assign remote_loop_active = s_r.remote;
	assign bp_clk_via_ja = s_r.bp_ja;
	assign irq_n = s_r.irq_n;
endmodule // loopback_status_interrupt_control
`default_nettype wire

// >>> verif/lsic_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lsic_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Host port
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic data_oe,
	// Sources and paths
	input wire loopback_pkg::stat_in_t stat_in,
	input wire loopback_pkg::path_in_t path_in,
	// Outputs
	input wire logic [2:0] err_count_sel,
	input wire logic remote_loop_active,
	input wire logic bp_clk_via_ja,
	input wire logic irq_n
);
	logic [3:0] wa_r;
	logic [3:0] ra_r;
	logic [3:0] sa_r;
	loopback_pkg::stat_in_t sq_r;
	// Saturating ages of last write, read and source change
	always_ff @(posedge ref_clk) begin
		sq_r <= stat_in;
		if (srst) begin
			wa_r <= 4'hF;
			ra_r <= 4'hF;
			sa_r <= 4'hF;
		end else begin
			wa_r <= !wr_n ? 4'h0 : wa_r + {3'h0, wa_r != 4'hF};
			ra_r <= !rd_n ? 4'h0 : ra_r + {3'h0, ra_r != 4'hF};
			sa_r <= stat_in != sq_r ? 4'h0 : sa_r + {3'h0, sa_r != 4'hF};
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_rst;
		$fell(srst) |-> irq_n && !remote_loop_active && !data_oe
			&& err_count_sel == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("not idle after reset");
	property p_sel;
		$changed(err_count_sel) |-> wa_r < 4'h8;
	endproperty
	a_sel: assert property (p_sel) else $error("select moved alone");
	property p_oe;
		$rose(data_oe) |-> !$past(rd_n, 2) && !$past(cs_n, 2);
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven unasked");
	property p_oe_end;
		$rose(rd_n) |-> ##[1:4] !data_oe;
	endproperty
	a_oe_end: assert property (p_oe_end) else $error("bus held");
	property p_irq_fall;
		$fell(irq_n) |-> sa_r < 4'h8 || wa_r < 4'h8;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq no cause");
	property p_irq_rise;
		$rose(irq_n) |-> ra_r < 4'h8 || wa_r < 4'h8;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq freed");
	property p_remote;
		$rose(remote_loop_active) |-> wa_r < 4'h8
			|| $past(stat_in.loop_up_det, 3);
	endproperty
	a_remote: assert property (p_remote) else $error("loop no cause");
	property p_bp;
		$stable(path_in.ja_en) [*5] |-> bp_clk_via_ja == path_in.ja_en;
	endproperty
	a_bp: assert property (p_bp) else $error("backplane path");
endmodule // lsic_monitor
bind loopback_status_interrupt_control lsic_monitor mon (.ref_clk, .srst,
	.cs_n, .rd_n, .wr_n, .data_oe, .stat_in, .path_in, .err_count_sel,
	.remote_loop_active, .bp_clk_via_ja, .irq_n);
`default_nettype wire

// >>> verif/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	// Clock
	input wire logic ref_clk,
	// Host strobes and bus
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] addr,
	output logic [7:0] data_in,
	// Read return
	input wire logic [7:0] data_out,
	input wire logic data_oe
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 8'h00;
		data_in = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		data_in <= d;
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		// Released bus no longer shows the value
		addr <= ~a;
		data_in <= ~d;
		repeat (5) @(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		d = 8'hXX;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		for (n = 0; n < 12 && data_oe !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
		if (data_oe === 1'b1) d = data_out;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask
endmodule // host_port_model
`default_nettype wire

// >>> verif/loopback_status_interrupt_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "loopback_map.svh"
module loopback_status_interrupt_control_test;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	wire logic cs_n, rd_n, wr_n, data_oe, bp, remote, irq_n;
	wire logic [7:0] addr, data_in, data_out;
	wire logic [2:0] sel;
	loopback_pkg::stat_in_t st = '0;
	loopback_pkg::path_in_t pin = '0;
	loopback_pkg::path_out_t pout;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [7:0] v;
	always #5 ref_clk = ~ref_clk;
	loopback_status_interrupt_control #(.HOLD_CYCLES(20)) DUT (.ref_clk,
		.srst, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
		.stat_in(st), .path_in(pin), .path_out(pout), .err_count_sel(sel),
		.remote_loop_active(remote), .bp_clk_via_ja(bp), .irq_n);
	host_port_model host (.ref_clk, .cs_n, .rd_n, .wr_n, .addr, .data_in,
		.data_out, .data_oe);
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk("reg", e, v);
	endtask
	// Mask write, read, masked write back
	task automatic stat(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		host.wr(a, m);
		host.rd(a, v);
		chk("status", e, v);
		host.wr(a, v & m);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic conclude();
		$display("TB: checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		wt(4);
		rdc(`ADDR_CTRL, 8'h00);
		rdc(`ADDR_IMR, 8'h00);
		rdc(8'h0F, 8'h00);
		chk("irq", 8'h01, {7'h00, irq_n});
		$display("test reset done");
		@(posedge ref_clk) pin.rec <= 2'h2;
		@(posedge ref_clk) pin.tx <= 2'h1;
		host.wr(`ADDR_CTRL, 8'h47);
		wt(6);
		chk("sel", 8'h07, {5'h00, sel});
		chk("remote", 8'h01, {7'h00, remote});
		chk("tx_drv", 8'h02, {6'h00, pout.tx_drv});
		rdc(`ADDR_CTRL, 8'h47);
		@(posedge ref_clk) pin.line_in <= 2'h3;
		host.wr(`ADDR_CTRL, 8'h10);
		wt(6);
		chk("rx_front", 8'h01, {6'h00, pout.rx_front});
		chk("tx_drv", 8'h01, {6'h00, pout.tx_drv});
		@(posedge ref_clk) pin.ja_out <= 2'h3;
		@(posedge ref_clk) pin.ja_en <= 1'b1;
		host.wr(`ADDR_CTRL, 8'h80);
		wt(6);
		chk("rx_out", 8'h03, {6'h00, pout.rx_out});
		chk("ja_in", 8'h01, {6'h00, pout.ja_in});
		chk("tx_drv", 8'h01, {6'h00, pout.tx_drv});
		chk("bp", 8'h01, {7'h00, bp});
		host.wr(`ADDR_CTRL, 8'h08);
		wt(6);
		chk("rx_out", 8'h02, {6'h00, pout.rx_out});
		chk("bp", 8'h01, {7'h00, bp});
		$display("test loops done");
		host.wr(`ADDR_IMR, 8'h08);
		@(posedge ref_clk) st.carrier_loss_alarm <= 1'b1;
		wt(8);
		chk("irq", 8'h00, {7'h00, irq_n});
		stat(`ADDR_SR, 8'h08, 8'h08);
		wt(4);
		chk("irq", 8'h01, {7'h00, irq_n});
		stat(`ADDR_SR, 8'h08, 8'h08);
		@(posedge ref_clk) st.carrier_loss_alarm <= 1'b0;
		wt(8);
		chk("irq", 8'h00, {7'h00, irq_n});
		stat(`ADDR_SR, 8'h08, 8'h08);
		stat(`ADDR_SR, 8'h08, 8'h00);
		chk("irq", 8'h01, {7'h00, irq_n});
		stat(`ADDR_RX_INFO_REG_1, 8'h10, 8'h10);
		$display("test alarm done");
		@(posedge ref_clk) st.prbs_det <= 1'b1;
		@(posedge ref_clk) st.zero_det <= 1'b1;
		@(posedge ref_clk) st.rx_info_reg_2_evt[7] <= 1'b1;
		wt(8);
		chk("irq", 8'h01, {7'h00, irq_n});
		host.wr(`ADDR_IMR, 8'h01);
		wt(4);
		chk("irq", 8'h00, {7'h00, irq_n});
		stat(`ADDR_SR, 8'h01, 8'h01);
		wt(4);
		chk("irq", 8'h01, {7'h00, irq_n});
		stat(`ADDR_RX_INFO_REG_1, 8'h80, 8'h80);
		stat(`ADDR_SR, 8'h08, 8'h01);
		stat(`ADDR_RX_INFO_REG_2, 8'h80, 8'h80);
		$display("test mask done");
		host.wr(`ADDR_CTRL, 8'h20);
		@(posedge ref_clk) st.loop_up_det <= 1'b1;
		wt(40);
		chk("remote", 8'h01, {7'h00, remote});
		stat(`ADDR_RX_INFO_REG_2, 8'h02, 8'h02);
		@(posedge ref_clk) st.loop_up_det <= 1'b0;
		@(posedge ref_clk) st.loop_down_det <= 1'b1;
		wt(40);
		chk("remote", 8'h00, {7'h00, remote});
		@(posedge ref_clk) st.loop_down_det <= 1'b0;
		@(posedge ref_clk) st.loop_up_det <= 1'b1;
		wt(40);
		chk("remote", 8'h01, {7'h00, remote});
		host.wr(`ADDR_CTRL, 8'h00);
		wt(4);
		chk("remote", 8'h00, {7'h00, remote});
		stat(`ADDR_RX_INFO_REG_2, 8'h02, 8'h00);
		$display("test auto done");
		conclude();
	end
endmodule // loopback_status_interrupt_control_test
`default_nettype wire
